// [hw/mssop_core.sv]
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "mssop_params.svh"

module mssop_core (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic INSTR_VALID,
    input wire mssop_pkg::mssop_instr_t INSTR,
    input wire logic [7:0] FILE_RD_DATA,
    input wire logic [3:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [7:0] BUS_RDATA,
    output logic [7:0] ACCUMULATOR,
    output mssop_pkg::mssop_flags_t FLAGS,
    output logic FILE_WR_EN,
    output logic [6:0] FILE_WR_ADDR,
    output logic [7:0] FILE_WR_DATA,
    output logic WATCHDOG_CLEAR,
    output logic PRESCALER_CLEAR,
    output logic HALT
);
    import mssop_pkg::*;

    // returns {carry, digit carry, result} of a + ~b + cin
    function automatic logic [9:0] sub_core(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        return {full[8], lo[4], full[7:0]};
    endfunction

    mssop_state_t state_r, state_nxt;
    logic [7:0] acc_r, acc_nxt;
    mssop_flags_t flags_r, flags_nxt;
    logic file_we_r, file_we_nxt;
    logic [6:0] file_addr_r, file_addr_nxt;
    logic [7:0] file_data_r, file_data_nxt;
    logic wd_clr_r, wd_clr_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [4:0] spage_sel_r, spage_sel_nxt;
    logic [7:0] spage_mem_r [0:31];
    logic spage_we;
    logic [4:0] spage_widx;
    logic [7:0] spage_wdata;
    logic exec;
    logic [9:0] sub_res;
    logic [7:0] dest_val;

    // instructions are ignored while halted; wake comes from the control register
    assign exec = INSTR_VALID && (state_r == MSSOP_RUN);

    always_comb begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        file_we_nxt = 1'b0;
        file_addr_nxt = file_addr_r;
        file_data_nxt = file_data_r;
        wd_clr_nxt = 1'b0;
        spage_sel_nxt = spage_sel_r;
        spage_we = 1'b0;
        spage_widx = INSTR.spage_idx;
        spage_wdata = acc_r;
        sub_res = 10'h000;
        dest_val = 8'h00;
        rdata_nxt = 8'h00;
        if (exec) begin
            unique case (INSTR.op)
                SUB_IMM_WITH_BORROW_OP: begin
                    sub_res = sub_core(INSTR.operand, acc_r, flags_r.carry);
                    acc_nxt = sub_res[7:0];
                    flags_nxt.carry = sub_res[9];
                    flags_nxt.digit_carry_flag = sub_res[8];
                    flags_nxt.zero = (sub_res[7:0] == 8'h00);
                end
                SUB_ACC_FROM_FILE_OP, NIBBLE_EXCHANGE_OP: begin
                    if (INSTR.op == SUB_ACC_FROM_FILE_OP) begin
                        sub_res = sub_core(FILE_RD_DATA, acc_r, 1'b1);
                        dest_val = sub_res[7:0];
                        flags_nxt.carry = sub_res[9];
                        flags_nxt.digit_carry_flag = sub_res[8];
                        flags_nxt.zero = (sub_res[7:0] == 8'h00);
                    end else begin
                        dest_val = {FILE_RD_DATA[3:0], FILE_RD_DATA[7:4]};
                    end
                    if (INSTR.dest_file) begin
                        file_we_nxt = 1'b1;
                        file_addr_nxt = INSTR.file_addr;
                        file_data_nxt = dest_val;
                    end else begin
                        acc_nxt = dest_val;
                    end
                end
                SPAGE_READ_OP: begin
                    acc_nxt = spage_mem_r[INSTR.spage_idx];
                end
                SPAGE_WRITE_OP: begin
                    spage_we = 1'b1;
                end
                MSSOP_OP_HALT: begin
                    wd_clr_nxt = 1'b1;
                    state_nxt = MSSOP_HALTED;
                    flags_nxt.timeout_flag_n = 1'b1;
                    flags_nxt.powerdown_flag_n = 1'b0;
                end
                default: begin
                end
            endcase
        end else if (BUS_WR) begin
            // bus writes yield to an executing instruction so its results stay exact
            unique case (BUS_ADDR)
                `MSSOP_ADDR_ACCUMULATOR: acc_nxt = BUS_WDATA;
                `MSSOP_ADDR_STATUS: begin
                    flags_nxt.carry = BUS_WDATA[`MSSOP_ST_CARRY];
                    flags_nxt.digit_carry_flag = BUS_WDATA[`MSSOP_ST_DIGIT_CARRY];
                    flags_nxt.zero = BUS_WDATA[`MSSOP_ST_ZERO];
                end
                `MSSOP_ADDR_CONTROL: begin
                    if (BUS_WDATA[`MSSOP_CTL_WAKE]) begin
                        state_nxt = MSSOP_RUN;
                    end
                end
                `MSSOP_ADDR_SPAGE_SEL: spage_sel_nxt = BUS_WDATA[4:0];
                default: begin
                end
            endcase
        end
        if (BUS_RD) begin
            unique case (BUS_ADDR)
                `MSSOP_ADDR_ACCUMULATOR: rdata_nxt = acc_r;
                `MSSOP_ADDR_STATUS: rdata_nxt = {3'h0, flags_r};
                `MSSOP_ADDR_CONTROL: rdata_nxt = {7'h00, state_r == MSSOP_HALTED};
                `MSSOP_ADDR_SPAGE_SEL: rdata_nxt = {3'h0, spage_sel_r};
                `MSSOP_ADDR_SPAGE_DATA: rdata_nxt = spage_mem_r[spage_sel_r];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_r <= MSSOP_RUN;
            acc_r <= `MSSOP_RST_ACCUMULATOR;
            flags_r <= `MSSOP_RST_FLAGS;
            file_we_r <= 1'b0;
            file_addr_r <= 7'h00;
            file_data_r <= 8'h00;
            wd_clr_r <= 1'b0;
            rdata_r <= 8'h00;
            spage_sel_r <= `MSSOP_RST_SPAGE_SEL;
            for (int i = 0; i < 32; i++) begin
                spage_mem_r[i] <= `MSSOP_RST_SPAGE;
            end
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            file_we_r <= file_we_nxt;
            file_addr_r <= file_addr_nxt;
            file_data_r <= file_data_nxt;
            wd_clr_r <= wd_clr_nxt;
            rdata_r <= rdata_nxt;
            spage_sel_r <= spage_sel_nxt;
            if (spage_we) begin
                spage_mem_r[spage_widx] <= spage_wdata;
            end
        end
    end

    assign BUS_RDATA = rdata_r;
    assign ACCUMULATOR = acc_r;
    assign FLAGS = flags_r;
    assign FILE_WR_EN = file_we_r;
    assign FILE_WR_ADDR = file_addr_r;
    assign FILE_WR_DATA = file_data_r;
    assign WATCHDOG_CLEAR = wd_clr_r;
    assign PRESCALER_CLEAR = wd_clr_r;
    assign HALT = (state_r == MSSOP_HALTED);

    // helper values for the checks
    logic [8:0] chk_sbc;
    logic [7:0] chk_sub;
    logic [7:0] chk_spage;
    assign chk_sbc = {1'b0, INSTR.operand} + {1'b0, ~acc_r} + {8'h00, flags_r.carry};
    assign chk_sub = 8'(FILE_RD_DATA - acc_r);
    assign chk_spage = spage_mem_r[INSTR.spage_idx];

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    a_sbc_result: assert property (exec && INSTR.op == SUB_IMM_WITH_BORROW_OP |=>
        ACCUMULATOR == $past(chk_sbc[7:0]) && FLAGS.zero == ($past(chk_sbc[7:0]) == 8'h00))
        else $error("immediate subtract result or zero wrong");
    a_sbc_borrow: assert property (exec && INSTR.op == SUB_IMM_WITH_BORROW_OP |=>
        FLAGS.carry == $past(chk_sbc[8]))
        else $error("immediate subtract carry wrong");
    a_sub_to_file: assert property (exec && INSTR.op == SUB_ACC_FROM_FILE_OP && INSTR.dest_file |=>
        // a back-to-back instruction may raise the strobe again
        FILE_WR_EN && FILE_WR_DATA == $past(chk_sub) && ACCUMULATOR == $past(acc_r) ##1
        (!FILE_WR_EN || $past(exec)))
        else $error("file subtract write-back wrong");
    a_sub_flags: assert property (exec && INSTR.op == SUB_ACC_FROM_FILE_OP |=>
        FLAGS.zero == ($past(chk_sub) == 8'h00) && FLAGS.carry == ($past(FILE_RD_DATA) >= $past(acc_r)))
        else $error("file subtract flags wrong");
    a_swap_result: assert property (exec && INSTR.op == NIBBLE_EXCHANGE_OP && !INSTR.dest_file |=>
        ACCUMULATOR == {$past(FILE_RD_DATA[3:0]), $past(FILE_RD_DATA[7:4])} && $stable(FLAGS) && !FILE_WR_EN)
        else $error("nibble swap wrong");
    a_spage_read: assert property (exec && INSTR.op == SPAGE_READ_OP |=>
        ACCUMULATOR == $past(chk_spage) && $stable(FLAGS))
        else $error("S-page read wrong");
    a_spage_write: assert property (exec && INSTR.op == SPAGE_WRITE_OP |=>
        spage_mem_r[$past(INSTR.spage_idx)] == $past(acc_r) && $stable(FLAGS))
        else $error("S-page write wrong");
    a_halt_clear: assert property (exec && INSTR.op == MSSOP_OP_HALT |=>
        WATCHDOG_CLEAR && PRESCALER_CLEAR && HALT ##1 !WATCHDOG_CLEAR && HALT)
        else $error("halt did not clear watchdog or enter halt");
    a_halt_flags: assert property (exec && INSTR.op == MSSOP_OP_HALT |=>
        FLAGS.timeout_flag_n && !FLAGS.powerdown_flag_n && FLAGS.zero == $past(flags_r.zero) &&
        FLAGS.carry == $past(flags_r.carry) && FLAGS.digit_carry_flag == $past(flags_r.digit_carry_flag))
        else $error("halt flags wrong");

    c_sbc_zero: cover property (exec && INSTR.op == SUB_IMM_WITH_BORROW_OP ##1 FLAGS.zero);
    c_sub_file: cover property (exec && INSTR.op == SUB_ACC_FROM_FILE_OP && INSTR.dest_file ##1 FILE_WR_EN);
    c_halt_wake: cover property (HALT ##1 BUS_WR && BUS_ADDR == `MSSOP_ADDR_CONTROL ##1 !HALT);
endmodule

// [hw/mssop_params.svh]
`ifndef MSSOP_PARAMS_SVH
`define MSSOP_PARAMS_SVH

// register offsets on the plain register port
`define MSSOP_ADDR_ACCUMULATOR 4'h0
`define MSSOP_ADDR_STATUS 4'h1
`define MSSOP_ADDR_CONTROL 4'h2
`define MSSOP_ADDR_SPAGE_SEL 4'h3
`define MSSOP_ADDR_SPAGE_DATA 4'h4

// status register field positions
`define MSSOP_ST_CARRY 0
`define MSSOP_ST_DIGIT_CARRY 1
`define MSSOP_ST_ZERO 2
`define MSSOP_ST_POWERDOWN_N 3
`define MSSOP_ST_TIMEOUT_N 4

// control register field positions
`define MSSOP_CTL_WAKE 0

// reset values
`define MSSOP_RST_ACCUMULATOR 8'h00
`define MSSOP_RST_SPAGE 8'h00
`define MSSOP_RST_SPAGE_SEL 5'h00
`define MSSOP_RST_FLAGS 5'h18

// every instruction of this group completes in this many cycles
`define MSSOP_OP_CYCLES 1

`endif

// [hw/mssop_pkg.sv]
package mssop_pkg;

    typedef enum logic [2:0] {
        MSSOP_OP_NONE = 3'h0,
        SUB_IMM_WITH_BORROW_OP = 3'h1,
        SUB_ACC_FROM_FILE_OP = 3'h3,
        NIBBLE_EXCHANGE_OP = 3'h2,
        SPAGE_READ_OP = 3'h6,
        SPAGE_WRITE_OP = 3'h7,
        MSSOP_OP_HALT = 3'h5
    } mssop_op_t;

    typedef struct packed {
        mssop_op_t op;
        logic [7:0] operand;
        logic [6:0] file_addr;
        logic dest_file;
        logic [4:0] spage_idx;
    } mssop_instr_t;

    typedef struct packed {
        logic timeout_flag_n;
        logic powerdown_flag_n;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } mssop_flags_t;

    typedef enum logic [0:0] {
        MSSOP_RUN = 1'b0,
        MSSOP_HALTED = 1'b1
    } mssop_state_t;

endpackage

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import mssop_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    mssop_instr_t instr = '0;
    logic [7:0] file_rd_data = 8'h00;
    logic [3:0] bus_addr = 4'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata, acc, file_wr_data;
    mssop_flags_t flags;
    logic file_wr_en, wd_clr, pre_clr, halt;
    logic [6:0] file_wr_addr;
    int bad_count = 0;
    int cmp_count = 0;
    logic [7:0] i_tab [6] = '{8'h05, 8'h05, 8'h06, 8'h06, 8'hFF, 8'h00};
    logic [7:0] a_tab [6] = '{8'h06, 8'h06, 8'h05, 8'h05, 8'h00, 8'hFF};
    logic [5:0] c_tab = 6'h1A;

    always #50 sys_clk = ~sys_clk;

    mssop_core i_dut (.SYS_CLK(sys_clk), .RESET(reset), .INSTR_VALID(instr_valid), .INSTR(instr),
        .FILE_RD_DATA(file_rd_data), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
        .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .ACCUMULATOR(acc), .FLAGS(flags),
        .FILE_WR_EN(file_wr_en), .FILE_WR_ADDR(file_wr_addr), .FILE_WR_DATA(file_wr_data),
        .WATCHDOG_CLEAR(wd_clr), .PRESCALER_CLEAR(pre_clr), .HALT(halt));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic op(input mssop_op_t o, input logic [7:0] i, input logic [6:0] fa, input logic dst,
        input logic [4:0] si, input logic [7:0] fr);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr <= '{o, i, fa, dst, si};
        file_rd_data <= fr;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // {digit carry, carry, result}; carry means no borrow
    function automatic logic [9:0] sub_ref(input logic [7:0] x, input logic [7:0] a, input logic cin);
        logic [8:0] s;
        logic [4:0] lo;
        s = {1'b0, x} + {1'b0, ~a} + 9'(cin);
        lo = {1'b0, x[3:0]} + {1'b0, ~a[3:0]} + 5'(cin);
        return {lo[4], s};
    endfunction

    function automatic logic [7:0] fl(input logic [9:0] r);
        return {5'h03, r[7:0] == 8'h00, r[9], r[8]};
    endfunction

    initial begin
        logic [7:0] d;
        logic [9:0] r;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk("acc reset", 8'h00, acc);
        chk("flags reset", 8'h18, {3'h0, flags});
        rd(4'hF, d);
        chk("unmapped read", 8'h00, d);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            wr(4'h0, a_tab[k]);
            wr(4'h1, {7'h00, c_tab[k]});
            op(SUB_IMM_WITH_BORROW_OP, i_tab[k], 7'h00, 1'b0, 5'h00, 8'h00);
            r = sub_ref(i_tab[k], a_tab[k], c_tab[k]);
            chk("imm sub acc", r[7:0], acc);
            chk("imm sub flags", fl(r), {3'h0, flags});
        end
        $display("test immediate subtract done");
        for (int k = 0; k < 2; k++) begin
            wr(4'h0, a_tab[k + 1]);
            wr(4'h1, {7'h00, k[0]});
            op(SUB_ACC_FROM_FILE_OP, 8'h00, 7'h7F, ~k[0], 5'h00, i_tab[k + 1]);
            r = sub_ref(i_tab[k + 1], a_tab[k + 1], 1'b1);
            chk("file sub flags", fl(r), {3'h0, flags});
            chk("file sub wr en", {7'h00, ~k[0]}, {7'h00, file_wr_en});
            chk("file sub acc", k[0] ? r[7:0] : a_tab[k + 1], acc);
            if (k == 0) begin
                chk("file sub data", r[7:0], file_wr_data);
                chk("file sub addr", 8'h7F, {1'b0, file_wr_addr});
            end
            @(posedge sys_clk);
            #1;
            chk("wr en pulse end", 8'h00, {7'h00, file_wr_en});
        end
        $display("test file subtract done");
        wr(4'h1, 8'h07);
        op(NIBBLE_EXCHANGE_OP, 8'h00, 7'h12, 1'b0, 5'h00, 8'hA5);
        chk("swap acc", 8'h5A, acc);
        op(NIBBLE_EXCHANGE_OP, 8'h00, 7'h12, 1'b1, 5'h00, 8'h3C);
        chk("swap data", 8'hC3, file_wr_data);
        chk("swap wr en", 8'h01, {7'h00, file_wr_en});
        chk("swap keeps acc", 8'h5A, acc);
        chk("swap flags", 8'h1F, {3'h0, flags});
        $display("test swap done");
        op(SPAGE_WRITE_OP, 8'h00, 7'h00, 1'b0, 5'h1F, 8'h00);
        wr(4'h0, 8'h96);
        op(SPAGE_WRITE_OP, 8'h00, 7'h00, 1'b0, 5'h00, 8'h00);
        wr(4'h3, 8'h1F);
        rd(4'h4, d);
        chk("spage 31 via port", 8'h5A, d);
        op(SPAGE_READ_OP, 8'h00, 7'h00, 1'b0, 5'h1F, 8'h00);
        chk("spage read 31", 8'h5A, acc);
        op(SPAGE_READ_OP, 8'h00, 7'h00, 1'b0, 5'h00, 8'h00);
        chk("spage read 0", 8'h96, acc);
        chk("spage flags", 8'h1F, {3'h0, flags});
        $display("test spage done");
        op(MSSOP_OP_HALT, 8'h00, 7'h00, 1'b0, 5'h00, 8'h00);
        chk("halt clears", 8'h03, {6'h00, wd_clr, pre_clr});
        chk("halt level", 8'h01, {7'h00, halt});
        chk("halt flags", 8'h17, {3'h0, flags});
        @(posedge sys_clk);
        #1;
        chk("clear pulse end", 8'h00, {6'h00, wd_clr, pre_clr});
        // halted core must ignore work
        op(SUB_IMM_WITH_BORROW_OP, 8'h10, 7'h00, 1'b0, 5'h00, 8'h00);
        chk("halted acc", 8'h96, acc);
        rd(4'h1, d);
        chk("halt flags via port", 8'h17, d);
        rd(4'h2, d);
        chk("halt state via port", 8'h01, d);
        @(posedge sys_clk);
        #1;
        chk("rdata one cycle", 8'h00, bus_rdata);
        wr(4'h2, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("wake", 8'h00, {7'h00, halt});
        op(MSSOP_OP_NONE, 8'hFF, 7'h00, 1'b0, 5'h00, 8'h00);
        chk("no-op acc", 8'h96, acc);
        chk("no-op flags", 8'h17, {3'h0, flags});
        rd(4'h0, d);
        chk("acc via port", 8'h96, d);
        $display("test halt done");
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk("acc mid reset", 8'h00, acc);
        chk("flags mid reset", 8'h18, {3'h0, flags});
        chk("halt mid reset", 8'h00, {7'h00, halt});
        $display("test mid reset done");
        give_verdict();
    end

    initial begin
        #400000;
        bad_count++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule
